// [iie_pkg.sv]
package iie_pkg;

	localparam int XLEN = 64;
	localparam int SHAMT_W = 5;
	localparam int PLUS32_OFFSET = 32;
	localparam int LINK_PC_OFFSET = 8;
	localparam int UPPER_IMM_SHIFT = 16;
	localparam int REGION_KEEP_LSB = 28;
	localparam int LINK_GPR_INDEX = 31;
	localparam int SR_ERL_BIT = 2;
	localparam int SR_EXL_BIT = 1;
	localparam int DIV_CYCLES = 64;
	localparam logic [63:0] PC_RESET = 64'h0000_0000_0000_0000;

	// operation codes presented by the decoder
	typedef enum logic [5:0] {
		IIE_NOP, IIE_ADD_IMM, IIE_ADD, IIE_CLO, IIE_CLZ,
		IIE_DIV_W, IIE_DIVU_W, IIE_DIV_D, IIE_DIVU_D,
		IIE_WORD_SIGNED_PRODUCT_W, IIE_MULTU_W, IIE_WORD_SIGNED_PRODUCT_D, IIE_MULTU_D,
		IIE_MUL_ACCUMULATE, IIE_MADDU, IIE_MUL_DEDUCT, IIE_MSUBU, IIE_MUL_REG,
		IIE_SLL, IIE_SRL, IIE_SRA, IIE_SLLV, IIE_SRLV, IIE_SRAV,
		IIE_SLL32, IIE_SRL32, IIE_SRA32, IIE_SUB,
		IIE_DEBUG_RETURN, IIE_EXCEPTION_RETURN, IIE_J, IIE_JAL, IIE_JR, IIE_REGISTER_BRANCH_LINK,
		IIE_LL_W, IIE_LL_D, IIE_SC_W, IIE_SC_D, IIE_LUI,
		IIE_SELECT_IF_FP_FALSE, IIE_SELECT_IF_FP_TRUE, IIE_SELECT_IF_NONZERO, IIE_SELECT_IF_ZERO, IIE_INDEXED_PREFETCH,
		IIE_MFC0, IIE_MTC0, IIE_MFC2, IIE_MTC2, IIE_COP2_DWORD_LOAD, IIE_COP2_WORD_LOAD
	} iie_op_t;

	typedef struct packed {
		iie_op_t op;
		logic [4:0] rd;
		logic [SHAMT_W-1:0] shamt;
		logic [2:0] sel;
		logic [2:0] cc_idx;
		logic [15:0] imm;
		logic [25:0] target;
		logic [63:0] rs_val;
		logic [63:0] rt_val;
		logic [4:0] rt;
	} iie_req_t;

	typedef struct packed {
		logic wr_en;
		logic [4:0] wr_idx;
		logic [63:0] wr_val;
	} iie_gpr_wr_t;

	typedef struct packed {
		logic rd_en;
		logic wr_en;
		logic is_word;
		logic [63:0] addr;
		logic [63:0] wdata;
		logic prefetch;
	} iie_mem_t;

	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [4:0] reg_idx;
		logic [2:0] sel;
		logic [63:0] wdata;
	} iie_cop_t;

	typedef enum logic [1:0] {IIE_IDLE, IIE_DIVIDING, IIE_MEMWAIT} iie_fsm_t;

	// whole module state as one record
	typedef struct packed {
		iie_fsm_t fsm;
		logic [63:0] pc;
		logic [63:0] hi;
		logic [63:0] lo;
		logic link_flag;
		logic [63:0] link_addr;
		logic debug_mode;
		logic [1:0] sr_exc;
		iie_gpr_wr_t gwr;
		iie_mem_t mem;
		iie_cop_t cop0;
		iie_cop_t cop2;
		logic [4:0] pend_idx;
		logic pend_word;
		logic pend_cop2;
		logic div_neg_q;
		logic div_neg_r;
		logic [6:0] div_cnt;
		logic [63:0] div_quo;
		logic [64:0] div_rem;
		logic [63:0] div_dvs;
		logic done;
	} iie_state_t;

	// leading-bit count across 64 bits
	function automatic logic [63:0] iie_lead_count(input logic [63:0] v, input logic ones);
		logic [63:0] n;
		logic stop;
		n = '0;
		stop = 1'b0;
		for (int i = 63; i >= 0; i--) begin
			if (!stop && (v[i] == ones)) begin
				n = n + 64'h1;
			end else begin
				stop = 1'b1;
			end
		end
		return n;
	endfunction : iie_lead_count

	// sign-extend the low word
	function automatic logic [63:0] iie_sext32(input logic [31:0] w);
		return {{32{w[31]}}, w};
	endfunction : iie_sext32

endpackage : iie_pkg

// [iie_exec.sv]
`timescale 1ns/10ps
// Functional notes
// - doubleword add, immediate or register, writes 64-bit sum to destination
// - doubleword leading ones/zeros count from bit 63 across full source
// - divide puts quotient in bottom product reg, remainder in upper
// - debug return loads pc from debug return pc, leaves debug mode
// - sysctl moves transfer between general register and cop0 reg by number, select
// - cop2 moves transfer registers; cop2 loads read memory base plus offset
// - multiply writes full double-width product into upper and bottom registers
// - fixed doubleword shifts by shift field: left, logical right, arithmetic right
// - variable doubleword shifts take count from low bits of first source
// - plus-32 shift forms shift by shift field plus 32
// - doubleword subtract writes first source minus second source
// - exception return picks error or exception pc, clears status bits, link flag
// - region jump keeps pc[63:28], appends offset<<2; link writes pc+8 to r31
// - register jump loads pc from source; link writes pc+8 to destination
// - linked loads load target, set link flag, record link address
// - conditional stores write only if link flag set, return flag in target
// - upper immediate load writes immediate shifted left by 16
// - multiply-add/subtract adds or subtracts product to/from upper:bottom pair
// - fp-conditional moves copy source when selected condition bit matches form
// - zero-conditional moves copy source when second source nonzero or zero
// - product-to-register writes destination; upper/bottom pair left unpredictable
// - indexed prefetch reads at sum of two registers, changes no register
module iie_exec
	import iie_pkg::*;
#(
	parameter int DIV_STEPS = DIV_CYCLES
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_req_valid,
	input wire iie_req_t i_req,
	input wire logic [7:0] i_fp_condition_bits,
	input wire logic [63:0] i_debug_return_pc,
	input wire logic [63:0] i_exception_return_pc,
	input wire logic [63:0] i_error_return_pc,
	input wire logic [63:0] i_cop0_rdata,
	input wire logic [63:0] i_cop2_rdata,
	input wire logic i_mem_ack,
	input wire logic [63:0] i_mem_rdata,
	output logic o_req_ready,
	output logic o_done,
	output iie_gpr_wr_t o_gpr_wr,
	output iie_mem_t o_mem,
	output iie_cop_t o_cop0,
	output iie_cop_t o_cop2,
	output logic [63:0] o_pc,
	output logic [63:0] o_product_upper_reg,
	output logic [63:0] o_product_bottom_reg,
	output logic o_link_flag,
	output logic [63:0] o_link_address,
	output logic o_debug_mode,
	output logic [1:0] o_status_exc_bits
);

	iie_state_t s_q;
	iie_state_t s_d;

	// shared operand arithmetic
	logic [63:0] rs;
	logic [63:0] rt;
	logic [63:0] imm_sext;
	logic [63:0] eff_addr;
	logic [127:0] prod_s;
	logic [127:0] prod_u;
	logic [127:0] acc;
	logic [5:0] sh_fixed;
	logic [5:0] sh_var;
	logic [5:0] sh_p32;

	assign rs = i_req.rs_val;
	assign rt = i_req.rt_val;
	assign imm_sext = {{48{i_req.imm[15]}}, i_req.imm};
	assign eff_addr = rs + imm_sext;
	assign acc = {s_q.hi, s_q.lo};
	// word forms multiply their low words separately; these wide products serve the doubleword, multiply-add/subtract and product-to-register forms
	assign prod_s = 128'($signed(rs) * $signed(rt));
	assign prod_u = rs * rt;
	assign sh_fixed = {1'b0, i_req.shamt};
	assign sh_var = {1'b0, rs[SHAMT_W-1:0]};
	assign sh_p32 = 6'(i_req.shamt + PLUS32_OFFSET);

	// next-state logic: one op per accepted request, divide is multi-cycle
	always_comb begin
		logic [64:0] trial;
		logic [63:0] a_abs;
		logic [63:0] b_abs;
		logic neg_a;
		logic neg_b;
		logic [63:0] a;
		logic [63:0] b;
		trial = '0;
		neg_a = 1'b0;
		neg_b = 1'b0;
		a = rs;
		b = rt;
		a_abs = '0;
		b_abs = '0;
		s_d = s_q;
		s_d.gwr = '0;
		s_d.mem = '0;
		s_d.cop0 = '0;
		s_d.cop2 = '0;
		s_d.done = 1'b0;
		unique case (s_q.fsm)
			IIE_IDLE: begin
				if (i_req_valid) begin
					s_d.done = 1'b1;
					s_d.gwr.wr_idx = i_req.rd;
					unique case (i_req.op)
						IIE_ADD_IMM: begin
							s_d.gwr = '{1'b1, i_req.rt, rs + imm_sext};
						end
						IIE_ADD: begin
							s_d.gwr = '{1'b1, i_req.rd, rs + rt};
						end
						IIE_SUB: begin
							s_d.gwr = '{1'b1, i_req.rd, rs - rt};
						end
						IIE_CLO: begin
							s_d.gwr = '{1'b1, i_req.rd, iie_lead_count(rs, 1'b1)};
						end
						IIE_CLZ: begin
							s_d.gwr = '{1'b1, i_req.rd, iie_lead_count(rs, 1'b0)};
						end
						IIE_DIV_W, IIE_DIVU_W, IIE_DIV_D, IIE_DIVU_D: begin
							if (i_req.op == IIE_DIV_W || i_req.op == IIE_DIVU_W) begin
								a = (i_req.op == IIE_DIV_W) ? iie_sext32(rs[31:0]) : {32'h0, rs[31:0]};
								b = (i_req.op == IIE_DIV_W) ? iie_sext32(rt[31:0]) : {32'h0, rt[31:0]};
							end
							if (i_req.op == IIE_DIV_W || i_req.op == IIE_DIV_D) begin
								neg_a = a[63];
								neg_b = b[63];
							end
							a_abs = neg_a ? -a : a;
							b_abs = neg_b ? -b : b;
							s_d.div_neg_q = neg_a ^ neg_b;
							s_d.div_neg_r = neg_a;
							s_d.div_quo = a_abs;
							s_d.div_rem = '0;
							s_d.div_dvs = b_abs;
							s_d.div_cnt = 7'(DIV_STEPS);
							s_d.fsm = IIE_DIVIDING;
							s_d.done = 1'b0;
						end
						IIE_WORD_SIGNED_PRODUCT_W: begin
							{s_d.hi, s_d.lo} = 128'($signed(iie_sext32(rs[31:0])) * $signed(iie_sext32(rt[31:0])));
						end
						IIE_MULTU_W: begin
							s_d.hi = 64'h0;
							s_d.lo = 64'(rs[31:0]) * 64'(rt[31:0]);
						end
						IIE_WORD_SIGNED_PRODUCT_D: begin
							{s_d.hi, s_d.lo} = prod_s;
						end
						IIE_MULTU_D: begin
							{s_d.hi, s_d.lo} = prod_u;
						end
						IIE_MUL_ACCUMULATE: begin
							{s_d.hi, s_d.lo} = acc + prod_s;
						end
						IIE_MADDU: begin
							{s_d.hi, s_d.lo} = acc + prod_u;
						end
						IIE_MUL_DEDUCT: begin
							{s_d.hi, s_d.lo} = acc - prod_s;
						end
						IIE_MSUBU: begin
							{s_d.hi, s_d.lo} = acc - prod_u;
						end
						IIE_MUL_REG: begin
							s_d.gwr = '{1'b1, i_req.rd, prod_s[63:0]};
						end
						IIE_SLL: begin
							s_d.gwr = '{1'b1, i_req.rd, rt << sh_fixed};
						end
						IIE_SRL: begin
							s_d.gwr = '{1'b1, i_req.rd, rt >> sh_fixed};
						end
						IIE_SRA: begin
							s_d.gwr = '{1'b1, i_req.rd, 64'($signed(rt) >>> sh_fixed)};
						end
						IIE_SLLV: begin
							s_d.gwr = '{1'b1, i_req.rd, rt << sh_var};
						end
						IIE_SRLV: begin
							s_d.gwr = '{1'b1, i_req.rd, rt >> sh_var};
						end
						IIE_SRAV: begin
							s_d.gwr = '{1'b1, i_req.rd, 64'($signed(rt) >>> sh_var)};
						end
						IIE_SLL32: begin
							s_d.gwr = '{1'b1, i_req.rd, rt << sh_p32};
						end
						IIE_SRL32: begin
							s_d.gwr = '{1'b1, i_req.rd, rt >> sh_p32};
						end
						IIE_SRA32: begin
							s_d.gwr = '{1'b1, i_req.rd, 64'($signed(rt) >>> sh_p32)};
						end
						IIE_DEBUG_RETURN: begin
							s_d.pc = i_debug_return_pc;
							s_d.debug_mode = 1'b0;
						end
						IIE_EXCEPTION_RETURN: begin
							s_d.pc = s_q.sr_exc[SR_ERL_BIT-1] ? i_error_return_pc
								: i_exception_return_pc;
							s_d.sr_exc = 2'h0;
							s_d.link_flag = 1'b0;
						end
						IIE_J, IIE_JAL: begin
							s_d.pc = {s_q.pc[63:REGION_KEEP_LSB], i_req.target, 2'h0};
							if (i_req.op == IIE_JAL) begin
								s_d.gwr = '{1'b1, 5'(LINK_GPR_INDEX), s_q.pc + 64'(LINK_PC_OFFSET)};
							end
						end
						IIE_JR, IIE_REGISTER_BRANCH_LINK: begin
							s_d.pc = rs;
							if (i_req.op == IIE_REGISTER_BRANCH_LINK) begin
								s_d.gwr = '{1'b1, i_req.rd, s_q.pc + 64'(LINK_PC_OFFSET)};
							end
						end
						IIE_LL_W, IIE_LL_D: begin
							s_d.mem = '{1'b1, 1'b0, i_req.op == IIE_LL_W, eff_addr, 64'h0, 1'b0};
							s_d.link_flag = 1'b1;
							s_d.link_addr = eff_addr;
							s_d.pend_idx = i_req.rt;
							s_d.pend_word = (i_req.op == IIE_LL_W);
							s_d.pend_cop2 = 1'b0;
							s_d.fsm = IIE_MEMWAIT;
							s_d.done = 1'b0;
						end
						IIE_SC_W, IIE_SC_D: begin
							s_d.mem = '{1'b0, s_q.link_flag, i_req.op == IIE_SC_W, eff_addr, rt, 1'b0};
							s_d.gwr = '{1'b1, i_req.rt, {63'h0, s_q.link_flag}};
						end
						IIE_LUI: begin
							s_d.gwr = '{1'b1, i_req.rt, 64'(imm_sext << UPPER_IMM_SHIFT)};
						end
						IIE_SELECT_IF_FP_FALSE, IIE_SELECT_IF_FP_TRUE: begin
							s_d.gwr = '{(i_fp_condition_bits[i_req.cc_idx] == (i_req.op == IIE_SELECT_IF_FP_TRUE)),
								i_req.rd, rs};
						end
						IIE_SELECT_IF_NONZERO, IIE_SELECT_IF_ZERO: begin
							s_d.gwr = '{((rt != 64'h0) == (i_req.op == IIE_SELECT_IF_NONZERO)), i_req.rd, rs};
						end
						IIE_INDEXED_PREFETCH: begin
							s_d.mem = '{1'b1, 1'b0, 1'b0, rs + rt, 64'h0, 1'b1};
						end
						IIE_MFC0: begin
							s_d.cop0 = '{1'b0, 1'b1, i_req.rd, i_req.sel, 64'h0};
							s_d.gwr = '{1'b1, i_req.rt, i_cop0_rdata};
						end
						IIE_MTC0: begin
							s_d.cop0 = '{1'b1, 1'b0, i_req.rd, i_req.sel, rt};
						end
						IIE_MFC2: begin
							s_d.cop2 = '{1'b0, 1'b1, i_req.rd, 3'h0, 64'h0};
							s_d.gwr = '{1'b1, i_req.rt, i_cop2_rdata};
						end
						IIE_MTC2: begin
							s_d.cop2 = '{1'b1, 1'b0, i_req.rd, 3'h0, rt};
						end
						IIE_COP2_DWORD_LOAD, IIE_COP2_WORD_LOAD: begin
							s_d.mem = '{1'b1, 1'b0, i_req.op == IIE_COP2_WORD_LOAD, eff_addr, 64'h0, 1'b0};
							s_d.pend_idx = i_req.rt;
							s_d.pend_word = (i_req.op == IIE_COP2_WORD_LOAD);
							s_d.pend_cop2 = 1'b1;
							s_d.fsm = IIE_MEMWAIT;
							s_d.done = 1'b0;
						end
						IIE_NOP: begin
						end
						default: begin
						end
					endcase
				end
			end
			// restoring divide, one quotient bit per cycle
			IIE_DIVIDING: begin
				trial = {s_q.div_rem[63:0], s_q.div_quo[63]} - {1'b0, s_q.div_dvs};
				if (!trial[64]) begin
					s_d.div_rem = trial;
					s_d.div_quo = {s_q.div_quo[62:0], 1'b1};
				end else begin
					s_d.div_rem = {s_q.div_rem[63:0], s_q.div_quo[63]};
					s_d.div_quo = {s_q.div_quo[62:0], 1'b0};
				end
				s_d.div_cnt = s_q.div_cnt - 7'h1;
				if (s_q.div_cnt == 7'h1) begin
					s_d.lo = s_q.div_neg_q ? -s_d.div_quo : s_d.div_quo;
					s_d.hi = s_q.div_neg_r ? -s_d.div_rem[63:0] : s_d.div_rem[63:0];
					s_d.fsm = IIE_IDLE;
					s_d.done = 1'b1;
				end
			end
			// hold the read until memory answers; the request stays up meanwhile
			IIE_MEMWAIT: begin
				s_d.mem = s_q.mem;
				if (i_mem_ack) begin
					s_d.mem = '0;
					s_d.fsm = IIE_IDLE;
					s_d.done = 1'b1;
					a = s_q.pend_word ? iie_sext32(i_mem_rdata[31:0]) : i_mem_rdata;
					if (s_q.pend_cop2) begin
						s_d.cop2 = '{1'b1, 1'b0, s_q.pend_idx, 3'h0, a};
					end else begin
						s_d.gwr = '{1'b1, s_q.pend_idx, a};
					end
				end
			end
			default: begin
				s_d.fsm = IIE_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_q <= '0;
			s_q.pc <= PC_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs come straight from the state record
	assign o_req_ready = (s_q.fsm == IIE_IDLE);
	assign o_done = s_q.done;
	assign o_gpr_wr = s_q.gwr;
	assign o_mem = s_q.mem;
	assign o_cop0 = s_q.cop0;
	assign o_cop2 = s_q.cop2;
	assign o_pc = s_q.pc;
	assign o_product_upper_reg = s_q.hi;
	assign o_product_bottom_reg = s_q.lo;
	assign o_link_flag = s_q.link_flag;
	assign o_link_address = s_q.link_addr;
	assign o_debug_mode = s_q.debug_mode;
	assign o_status_exc_bits = s_q.sr_exc;

endmodule : iie_exec

// [iie_exec_chk.sv]
`timescale 1ns/10ps
module iie_exec_chk
	import iie_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_req_valid,
	input wire iie_req_t i_req,
	input wire logic [63:0] i_debug_return_pc,
	input wire logic [63:0] i_exception_return_pc,
	input wire logic [63:0] i_error_return_pc,
	input wire logic i_mem_ack,
	input wire logic o_req_ready,
	input wire iie_gpr_wr_t o_gpr_wr,
	input wire iie_mem_t o_mem,
	input wire iie_cop_t o_cop0,
	input wire logic [63:0] o_pc,
	input wire logic o_link_flag,
	input wire logic [63:0] o_link_address,
	input wire logic o_debug_mode,
	input wire logic [1:0] o_status_exc_bits
);
	default clocking dc @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_b);

	// request accepted at this edge
	logic take;
	assign take = i_req_valid && o_req_ready;

	AST_ADD_SUM: assert property (take && i_req.op == IIE_ADD |=> o_gpr_wr.wr_en &&
		o_gpr_wr.wr_idx == $past(i_req.rd) && o_gpr_wr.wr_val == $past(i_req.rs_val) + $past(i_req.rt_val))
		else $error("add result wrong");
	AST_SUB_DIFF: assert property (take && i_req.op == IIE_SUB |=>
		o_gpr_wr.wr_val == $past(i_req.rs_val) - $past(i_req.rt_val)) else $error("sub wrong");
	AST_LUI_SHIFT: assert property (take && i_req.op == IIE_LUI |=> o_gpr_wr.wr_en &&
		o_gpr_wr.wr_val[31:0] == {$past(i_req.imm), 16'h0000}) else $error("upper load wrong");
	AST_REG_JUMP: assert property (take && i_req.op == IIE_JR |=>
		o_pc == $past(i_req.rs_val)) else $error("register jump pc wrong");
	AST_EXCEPTION_RETURN_TARGET: assert property (take && i_req.op == IIE_EXCEPTION_RETURN |=>
		o_pc == ($past(o_status_exc_bits[1]) ? $past(i_error_return_pc) : $past(i_exception_return_pc))
		&& o_status_exc_bits == 2'h0 && !o_link_flag) else $error("exception return wrong");
	AST_DEBUG_RETURN_EXIT: assert property (take && i_req.op == IIE_DEBUG_RETURN |=>
		o_pc == $past(i_debug_return_pc) && !o_debug_mode) else $error("debug return wrong");
	AST_LINK_ADDR: assert property (take && i_req.op inside {IIE_LL_W, IIE_LL_D} |=>
		o_link_flag && o_mem.rd_en && o_link_address == o_mem.addr
		&& o_link_address == $past(i_req.rs_val) + 64'($signed($past(i_req.imm))))
		else $error("link state wrong");
	AST_SC_GATE: assert property (take && i_req.op inside {IIE_SC_W, IIE_SC_D} |=>
		o_mem.wr_en == $past(o_link_flag) && o_gpr_wr.wr_val == {63'h0, $past(o_link_flag)})
		else $error("conditional store wrong");
	AST_COP0_WRITE: assert property (take && i_req.op == IIE_MTC0 |=> o_cop0.wr_en &&
		o_cop0.reg_idx == $past(i_req.rd) && o_cop0.sel == $past(i_req.sel)
		&& o_cop0.wdata == $past(i_req.rt_val)) else $error("cop0 write wrong");
	AST_PREFETCH: assert property (take && i_req.op == IIE_INDEXED_PREFETCH |=> o_mem.prefetch &&
		o_mem.addr == $past(i_req.rs_val) + $past(i_req.rt_val) && !o_gpr_wr.wr_en)
		else $error("prefetch wrong");

	// main scenarios reached
	COV_EXCEPTION_RETURN: cover property (take && i_req.op == IIE_EXCEPTION_RETURN);
	COV_ACK: cover property (o_mem.rd_en && i_mem_ack);
	COV_DIV: cover property (take && i_req.op == IIE_DIV_D);
endmodule : iie_exec_chk

bind iie_exec iie_exec_chk iie_exec_chk_inst (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
	.i_req_valid(i_req_valid), .i_req(i_req), .i_debug_return_pc(i_debug_return_pc),
	.i_exception_return_pc(i_exception_return_pc), .i_error_return_pc(i_error_return_pc),
	.i_mem_ack(i_mem_ack), .o_req_ready(o_req_ready), .o_gpr_wr(o_gpr_wr), .o_mem(o_mem),
	.o_cop0(o_cop0), .o_pc(o_pc), .o_link_flag(o_link_flag), .o_link_address(o_link_address),
	.o_debug_mode(o_debug_mode), .o_status_exc_bits(o_status_exc_bits));

// [test_integer_instruction_execution.sv]
`timescale 1ns/10ps
module test_integer_instruction_execution;
	import iie_pkg::*;
	logic i_ref_clk, i_rst_b, i_req_valid, i_mem_ack;
	iie_req_t i_req;
	logic [7:0] i_fp_condition_bits;
	logic [63:0] i_debug_return_pc, i_exception_return_pc, i_error_return_pc;
	logic [63:0] i_cop0_rdata, i_cop2_rdata, i_mem_rdata;
	logic o_req_ready, o_done, o_link_flag, o_debug_mode;
	iie_gpr_wr_t o_gpr_wr;
	iie_mem_t o_mem;
	iie_cop_t o_cop0, o_cop2;
	logic [63:0] o_pc, o_product_upper_reg, o_product_bottom_reg, o_link_address;
	logic [1:0] o_status_exc_bits;
	logic [68:0] exp_q[$];
	int n_mismatch = 0;
	int cmp_count = 0;
	logic [63:0] seed = 64'h3B;
	iie_op_t tbl[$] = {IIE_ADD, IIE_ADD_IMM, IIE_SUB, IIE_CLO, IIE_CLZ, IIE_SLL, IIE_SRL,
		IIE_SRA, IIE_SLLV, IIE_SRLV, IIE_SRAV, IIE_SLL32, IIE_SRL32, IIE_SRA32, IIE_LUI,
		IIE_SELECT_IF_NONZERO, IIE_SELECT_IF_ZERO, IIE_SELECT_IF_FP_FALSE, IIE_SELECT_IF_FP_TRUE, IIE_MFC0, IIE_MFC2, IIE_MTC0, IIE_INDEXED_PREFETCH, IIE_MUL_REG};

	iie_exec iie_exec_inst (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_req_valid(i_req_valid),
		.i_req(i_req), .i_fp_condition_bits(i_fp_condition_bits),
		.i_debug_return_pc(i_debug_return_pc), .i_exception_return_pc(i_exception_return_pc),
		.i_error_return_pc(i_error_return_pc), .i_cop0_rdata(i_cop0_rdata),
		.i_cop2_rdata(i_cop2_rdata), .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata),
		.o_req_ready(o_req_ready), .o_done(o_done), .o_gpr_wr(o_gpr_wr), .o_mem(o_mem),
		.o_cop0(o_cop0), .o_cop2(o_cop2), .o_pc(o_pc), .o_product_upper_reg(o_product_upper_reg),
		.o_product_bottom_reg(o_product_bottom_reg), .o_link_flag(o_link_flag),
		.o_link_address(o_link_address), .o_debug_mode(o_debug_mode),
		.o_status_exc_bits(o_status_exc_bits));

	// xorshift source, fixed start so runs repeat
	function automatic logic [63:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 7;
		seed ^= seed << 17;
		return seed;
	endfunction : rnd

	// random request; count ops get varied run lengths
	function automatic iie_req_t rand_req(input iie_op_t op);
		iie_req_t r;
		r = iie_req_t'({rnd(), rnd(), rnd(), rnd()});
		r.op = op;
		if (r.rt[0]) r.rt_val = '0;
		if (op == IIE_CLO || op == IIE_CLZ) r.rs_val = (r.rs_val >> r.shamt) ^ {64{op == IIE_CLO}};
		return r;
	endfunction : rand_req

	// expected register write {enable, index, value}
	function automatic logic [69:0] model(input iie_req_t r);
		logic [63:0] v;
		logic [4:0] ix;
		logic en;
		int n;
		en = 1'b1;
		ix = r.rd;
		v = r.rs_val;
		n = 0;
		case (r.op)
			IIE_ADD: v = r.rs_val + r.rt_val;
			IIE_ADD_IMM: begin
				v = r.rs_val + {{48{r.imm[15]}}, r.imm};
				ix = r.rt;
			end
			IIE_SUB: v = r.rs_val - r.rt_val;
			IIE_MUL_REG: v = r.rs_val * r.rt_val;
			IIE_CLO, IIE_CLZ: begin
				while (n < 64 && r.rs_val[63 - n] == (r.op == IIE_CLO)) n++;
				v = 64'(n);
			end
			IIE_SLL: v = r.rt_val << r.shamt;
			IIE_SRL: v = r.rt_val >> r.shamt;
			IIE_SRA: v = $signed(r.rt_val) >>> r.shamt;
			IIE_SLLV: v = r.rt_val << r.rs_val[4:0];
			IIE_SRLV: v = r.rt_val >> r.rs_val[4:0];
			IIE_SRAV: v = $signed(r.rt_val) >>> r.rs_val[4:0];
			IIE_SLL32: v = r.rt_val << {1'b1, r.shamt};
			IIE_SRL32: v = r.rt_val >> {1'b1, r.shamt};
			IIE_SRA32: v = $signed(r.rt_val) >>> {1'b1, r.shamt};
			IIE_LUI: begin
				v = {{32{r.imm[15]}}, r.imm, 16'h0000};
				ix = r.rt;
			end
			IIE_SELECT_IF_NONZERO, IIE_SELECT_IF_ZERO: en = (r.rt_val != 0) == (r.op == IIE_SELECT_IF_NONZERO);
			IIE_SELECT_IF_FP_FALSE, IIE_SELECT_IF_FP_TRUE: en = i_fp_condition_bits[r.cc_idx] == (r.op == IIE_SELECT_IF_FP_TRUE);
			IIE_MFC0, IIE_MFC2: begin
				v = (r.op == IIE_MFC0) ? i_cop0_rdata : i_cop2_rdata;
				ix = r.rt;
			end
			default: en = 1'b0;
		endcase
		return {en, ix, v};
	endfunction : model

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// present one request, hold it until taken
	task automatic issue(input iie_req_t r);
		logic [69:0] m;
		@(negedge i_ref_clk);
		i_req_valid = 1'b1;
		i_req = r;
		i_cop0_rdata = rnd();
		i_cop2_rdata = rnd();
		i_fp_condition_bits = 8'(rnd());
		m = model(r);
		if (m[69]) exp_q.push_back(m[68:0]);
		while (o_req_ready !== 1'b1) @(negedge i_ref_clk);
		@(posedge i_ref_clk);
	endtask : issue

	task automatic idle();
		@(negedge i_ref_clk);
		i_req_valid = 1'b0;
	endtask : idle

	task automatic wait_done();
		for (int k = 0; k < 300 && o_done !== 1'b1; k++) @(negedge i_ref_clk);
	endtask : wait_done

	task automatic end_of_test();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test

	initial begin
		i_ref_clk = 1'b0;
		forever #4 i_ref_clk = ~i_ref_clk;
	end

	// oldest expected write against each write seen
	always @(negedge i_ref_clk) begin
		if (i_rst_b && o_gpr_wr.wr_en !== 1'b0) begin
			if (exp_q.size() == 0) begin
				n_mismatch++;
				$display("ERROR %0t unexpected register write", $time);
			end else begin
				chk({o_gpr_wr.wr_idx, o_gpr_wr.wr_val}, exp_q.pop_front());
			end
		end
	end

	// hang guard, far beyond the few hundred cycles needed
	initial begin
		repeat (5000) @(posedge i_ref_clk);
		n_mismatch++;
		end_of_test();
	end

	initial begin
		iie_req_t r;
		iie_op_t op;
		logic [127:0] a, b, p;
		logic [63:0] x, v;
		i_rst_b = 1'b0;
		i_req_valid = 1'b0;
		i_req = '0;
		i_fp_condition_bits = '0;
		i_cop0_rdata = '0;
		i_cop2_rdata = '0;
		i_mem_ack = 1'b0;
		i_mem_rdata = '0;
		i_debug_return_pc = rnd();
		i_exception_return_pc = rnd();
		i_error_return_pc = rnd();
		repeat (5) @(negedge i_ref_clk);
		i_rst_b = 1'b1;
		// back-to-back single-cycle ops
		for (int k = 0; k < 3; k++) begin
			foreach (tbl[j]) issue(rand_req(tbl[j]));
		end
		idle();
		// products and quotient pairs, signed then unsigned; word forms use only low words
		for (int s = 0; s < 6; s++) begin
			op = s[0] ? IIE_MULTU_D : IIE_WORD_SIGNED_PRODUCT_D;
			if (s[1]) op = s[0] ? IIE_DIVU_D : IIE_DIV_D;
			if (s[2]) op = s[0] ? IIE_MULTU_W : IIE_WORD_SIGNED_PRODUCT_W;
			r = rand_req(op);
			if (s[1]) r.rt_val = (r.rt_val >> 40) | 64'h1;
			issue(r);
			idle();
			wait_done();
			chk(o_done, 1'b1);
			x = s[2] ? (s[0] ? 64'(r.rs_val[31:0]) : 64'($signed(r.rs_val[31:0]))) : r.rs_val;
			v = s[2] ? (s[0] ? 64'(r.rt_val[31:0]) : 64'($signed(r.rt_val[31:0]))) : r.rt_val;
			a = s[0] ? 128'(x) : 128'($signed(x));
			b = s[0] ? 128'(v) : 128'($signed(v));
			p = a * b;
			if (s[1]) p = s[0] ? {64'(a % b), 64'(a / b)} :
				{64'($signed(a) % $signed(b)), 64'($signed(a) / $signed(b))};
			chk({o_product_upper_reg, o_product_bottom_reg}, p);
		end
		// register jump then region jump with link, back to back
		r = rand_req(IIE_JR);
		x = r.rs_val;
		issue(r);
		r = rand_req(IIE_JAL);
		exp_q.push_back({5'd31, x + 64'h8});
		issue(r);
		idle();
		x = {x[63:28], r.target, 2'b00};
		chk(o_pc, x);
		r = rand_req(IIE_REGISTER_BRANCH_LINK);
		exp_q.push_back({r.rd, x + 64'h8});
		issue(r);
		idle();
		chk(o_pc, r.rs_val);
		// linked load with a slow reply, then conditional stores
		r = rand_req(IIE_LL_D);
		v = rnd();
		exp_q.push_back({r.rt, v});
		issue(r);
		idle();
		repeat (3) @(negedge i_ref_clk);
		i_mem_ack = 1'b1;
		i_mem_rdata = v;
		@(negedge i_ref_clk);
		i_mem_ack = 1'b0;
		i_mem_rdata = ~v;
		chk(o_link_flag, 1'b1);
		chk(o_link_address, r.rs_val + {{48{r.imm[15]}}, r.imm});
		// word load into coprocessor 2 comes back sign-extended
		r = rand_req(IIE_COP2_WORD_LOAD);
		issue(r);
		idle();
		i_mem_ack = 1'b1;
		i_mem_rdata = v;
		@(negedge i_ref_clk);
		i_mem_ack = 1'b0;
		chk(o_cop2, {1'b1, 1'b0, r.rt, 3'h0, {32{v[31]}}, v[31:0]});
		r = rand_req(IIE_SC_D);
		exp_q.push_back({r.rt, 64'h1});
		issue(r);
		issue(rand_req(IIE_EXCEPTION_RETURN));
		idle();
		chk(o_pc, i_exception_return_pc);
		chk(o_link_flag, 1'b0);
		r = rand_req(IIE_SC_D);
		exp_q.push_back({r.rt, 64'h0});
		issue(r);
		issue(rand_req(IIE_DEBUG_RETURN));
		idle();
		chk(o_pc, i_debug_return_pc);
		chk(o_debug_mode, 1'b0);
		repeat (2) @(negedge i_ref_clk);
		chk(exp_q.size(), 0);
		end_of_test();
	end
endmodule : test_integer_instruction_execution
